// *** cursor_sizing_pkg.sv ***
// Functional notes
// - In single panel mode, screen block three gets the smaller of the block one and block two line counts, with no setting of its own.
// - Block four always, and block three in dual panel mode, take their line counts from the lines-per-frame field, so software never programs them.
// - In dual panel mode, the lines by which block one and block two fall short of half the frame are blanked.
// - With indirect addressing the host issues the cursor-form command and its two parameter bytes load width then height/shape.
// - Width register bits 3-0 hold the cursor width in pixels from the character origin, minus one.
// - Height/shape register bit 7 selects the shape: 0 underscore, 1 solid block.
// - For the underscore shape the height field is the line of the underscore below the character origin.
// - For the block shape the height field is the vertical extent of the block from the character origin.
// - Height/shape register bits 3-0 hold the cursor height or position in lines, minus one.
// - The block two size field is the number of lines in that block minus one.
`default_nettype none
package cursor_sizing_pkg;
	// Register map
	localparam logic [7:0] CURSOR_WIDTH_OFFSET = 8'h15;
	localparam logic [7:0] CURSOR_HEIGHT_OFFSET = 8'h16;
	localparam logic [7:0] CURSOR_WIDTH_RESET = 8'h00;
	localparam logic [7:0] CURSOR_HEIGHT_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
	// Field layout
	localparam int CURSOR_FIELD_LSB = 0;
	localparam int CURSOR_FIELD_MSB = 3;
	localparam int CURSOR_SHAPE_BIT = 7;
	localparam logic [7:0] CURSOR_WIDTH_MASK = 8'h0f;
	localparam logic [7:0] CURSOR_HEIGHT_MASK = 8'h8f;
	localparam logic CURSOR_SHAPE_UNDERSCORE = 1'b0;
	localparam logic CURSOR_SHAPE_BLOCK = 1'b1;
	// Indirect command code, value arbitrary
	localparam logic [7:0] CURSOR_FORM_COMMAND_CODE = 8'h01;
	// Synchroniser depth and host pin bundle width
	localparam int SYNC_STAGES = 2;
	localparam int HOST_PIN_WIDTH = 20;
	typedef enum {CMD_IDLE, CMD_WAIT_WIDTH, CMD_WAIT_HEIGHT} cmd_state_type;
	typedef struct packed {
		logic shape;
		logic [3:0] height;
		logic [3:0] width;
	} cursor_cfg_type;
	typedef struct packed {
		logic wr_n;
		logic rd_n;
		logic cmd;
		logic indirect;
		logic [7:0] addr;
		logic [7:0] data;
	} host_pins_type;
	typedef struct packed {
		logic [7:0] block_three_line_count;
		logic [7:0] block_four_line_count;
		logic [7:0] block_one_blank_lines;
		logic [7:0] block_two_blank_lines;
	} block_sizes_type;
endpackage
`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync
	import cursor_sizing_pkg::*;
#(
	parameter int WIDTH = HOST_PIN_WIDTH,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage_one_reg;
	logic [WIDTH-1:0] stage_two_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage_one_reg <= RESET_VALUE;
			stage_two_reg <= RESET_VALUE;
		end else begin
			stage_one_reg <= async_i;
			stage_two_reg <= stage_one_reg;
		end
	end

	assign sync_o = stage_two_reg;
endmodule // pin_sync
`default_nettype wire

// *** block_sizer.sv ***
`timescale 1ns/100ps
`default_nettype none
module block_sizer
	import cursor_sizing_pkg::*;
(
	// Screen geometry
	input wire logic [7:0] block_one_line_count_i,
	input wire logic [7:0] block_two_line_count_i,
	input wire logic [7:0] lines_per_frame_i,
	input wire logic dual_panel_i,
	// Derived sizes
	output block_sizes_type sizes_o
);
	logic [8:0] half_lines;
	logic [8:0] block_one_lines;
	logic [8:0] block_two_lines;
	logic [7:0] smaller_block;

	// Counts are stored minus one, so add one to get real lines
	assign block_one_lines = {1'b0, block_one_line_count_i} + 9'h001;
	assign block_two_lines = {1'b0, block_two_line_count_i} + 9'h001;
	assign half_lines = ({1'b0, lines_per_frame_i} + 9'h001) >> 1;
	assign smaller_block = (block_one_line_count_i < block_two_line_count_i) ?
		block_one_line_count_i : block_two_line_count_i;

	always_comb begin
		sizes_o = '0;
		if (dual_panel_i) begin
			// Lower panel blocks each take half the frame
			sizes_o.block_three_line_count = 8'(half_lines - 9'h001);
			sizes_o.block_four_line_count = 8'(half_lines - 9'h001);
			if (block_one_lines < half_lines) begin
				sizes_o.block_one_blank_lines = 8'(half_lines - block_one_lines);
			end
			if (block_two_lines < half_lines) begin
				sizes_o.block_two_blank_lines = 8'(half_lines - block_two_lines);
			end
		end else begin
			sizes_o.block_three_line_count = smaller_block;
			sizes_o.block_four_line_count = lines_per_frame_i;
		end
	end
endmodule // block_sizer
`default_nettype wire

// *** lcd_cursor_shape_and_block_sizing.sv ***
`timescale 1ns/100ps
`default_nettype none
module lcd_cursor_shape_and_block_sizing
	import cursor_sizing_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Host processor pins
	input wire logic host_wr_n_i,
	input wire logic host_rd_n_i,
	input wire logic host_cmd_i,
	input wire logic host_indirect_i,
	input wire logic [7:0] host_addr_i,
	input wire logic [7:0] host_data_i,
	output logic [7:0] host_data_o,
	output logic host_data_oe_o,
	// Screen geometry from the register bank
	input wire logic [7:0] block_one_line_count_i,
	input wire logic [7:0] block_two_line_count_i,
	input wire logic [7:0] lines_per_frame_i,
	input wire logic dual_panel_i,
	// Refresh timing
	input wire logic frame_start_i,
	input wire logic at_cursor_address_i,
	input wire logic [3:0] cell_pixel_i,
	input wire logic [3:0] cell_line_i,
	// Derived block sizes
	output logic [7:0] block_three_line_count_o,
	output logic [7:0] block_four_line_count_o,
	output logic [7:0] block_one_blank_lines_o,
	output logic [7:0] block_two_blank_lines_o,
	// Cursor drawing
	output logic cursor_pixel_o,
	output logic cursor_shape_select_o,
	output logic [3:0] cursor_horizontal_field_o,
	output logic [3:0] cursor_vertical_field_o
);
	host_pins_type pins_raw;
	host_pins_type pins_sync;
	logic wr_n_prev_reg;
	logic write_pulse;
	logic direct_write;
	logic indirect_cmd_write;
	logic indirect_param_write;
	logic read_active;
	logic [7:0] cursor_width_reg;
	logic [7:0] cursor_width_next;
	logic [7:0] cursor_height_reg;
	logic [7:0] cursor_height_next;
	cmd_state_type cmd_state_reg;
	cmd_state_type cmd_state_next;
	cursor_cfg_type pending_cfg;
	cursor_cfg_type active_cfg_reg;
	block_sizes_type sizes;
	logic [7:0] read_value;
	logic cursor_hit;

	// Host pins cross into the system clock
	assign pins_raw.wr_n = host_wr_n_i;
	assign pins_raw.rd_n = host_rd_n_i;
	assign pins_raw.cmd = host_cmd_i;
	assign pins_raw.indirect = host_indirect_i;
	assign pins_raw.addr = host_addr_i;
	assign pins_raw.data = host_data_i;

	// Strobes idle high; address and data must be steady while a strobe is low
	pin_sync #(
		.WIDTH(HOST_PIN_WIDTH),
		.RESET_VALUE(20'hc0000)
	) host_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i(pins_raw),
		.sync_o(pins_sync)
	);

	// Falling edge of the synchronised write strobe
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_n_prev_reg <= 1'b1;
		end else begin
			wr_n_prev_reg <= pins_sync.wr_n;
		end
	end

	assign write_pulse = wr_n_prev_reg && !pins_sync.wr_n;
	assign direct_write = write_pulse && !pins_sync.indirect;
	assign indirect_cmd_write = write_pulse && pins_sync.indirect && pins_sync.cmd;
	assign indirect_param_write = write_pulse && pins_sync.indirect && !pins_sync.cmd;
	assign read_active = !pins_sync.rd_n && pins_sync.wr_n;

	// Indirect command sequencer
	always_comb begin
		cmd_state_next = cmd_state_reg;
		case (cmd_state_reg)
			CMD_IDLE: begin
				if (indirect_cmd_write && pins_sync.data == CURSOR_FORM_COMMAND_CODE) begin
					cmd_state_next = CMD_WAIT_WIDTH;
				end
			end
			CMD_WAIT_WIDTH: begin
				if (indirect_param_write) begin
					cmd_state_next = CMD_WAIT_HEIGHT;
				end
			end
			CMD_WAIT_HEIGHT: begin
				if (indirect_param_write) begin
					cmd_state_next = CMD_IDLE;
				end
			end
			default: begin
				cmd_state_next = CMD_IDLE;
			end
		endcase
		// Any new command abandons a half-finished parameter list
		if (indirect_cmd_write) begin
			if (pins_sync.data == CURSOR_FORM_COMMAND_CODE) begin
				cmd_state_next = CMD_WAIT_WIDTH;
			end else begin
				cmd_state_next = CMD_IDLE;
			end
		end
		// Dropping back to direct mode also ends the sequence
		if (!pins_sync.indirect) begin
			cmd_state_next = CMD_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_state_reg <= CMD_IDLE;
		end else begin
			cmd_state_reg <= cmd_state_next;
		end
	end

	// Width register: direct write or first cursor-form parameter
	always_comb begin
		cursor_width_next = cursor_width_reg;
		if (direct_write && pins_sync.addr == CURSOR_WIDTH_OFFSET) begin
			cursor_width_next = pins_sync.data & CURSOR_WIDTH_MASK;
		end else if (indirect_param_write && cmd_state_reg == CMD_WAIT_WIDTH) begin
			cursor_width_next = pins_sync.data & CURSOR_WIDTH_MASK;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cursor_width_reg <= CURSOR_WIDTH_RESET;
		end else begin
			cursor_width_reg <= cursor_width_next;
		end
	end

	// Height and shape register: direct write or second parameter
	always_comb begin
		cursor_height_next = cursor_height_reg;
		if (direct_write && pins_sync.addr == CURSOR_HEIGHT_OFFSET) begin
			cursor_height_next = pins_sync.data & CURSOR_HEIGHT_MASK;
		end else if (indirect_param_write && cmd_state_reg == CMD_WAIT_HEIGHT) begin
			cursor_height_next = pins_sync.data & CURSOR_HEIGHT_MASK;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cursor_height_reg <= CURSOR_HEIGHT_RESET;
		end else begin
			cursor_height_reg <= cursor_height_next;
		end
	end

	// Reads; unused bits come back as zero
	always_comb begin
		read_value = UNMAPPED_READ_VALUE;
		if (!pins_sync.indirect) begin
			case (pins_sync.addr)
				CURSOR_WIDTH_OFFSET: read_value = cursor_width_reg;
				CURSOR_HEIGHT_OFFSET: read_value = cursor_height_reg;
				default: read_value = UNMAPPED_READ_VALUE;
			endcase
		end
	end

	// Idle bus value is zero, so nothing stale leaks onto the pins
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			host_data_o <= UNMAPPED_READ_VALUE;
		end else begin
			host_data_o <= read_active ? read_value : UNMAPPED_READ_VALUE;
		end
	end

	// Drive only while the synced read strobe is low; released three clocks late
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			host_data_oe_o <= 1'b0;
		end else begin
			host_data_oe_o <= read_active;
		end
	end

	// Settings move to the drawing copy only at frame start, so no frame tears
	assign pending_cfg.shape = cursor_height_reg[CURSOR_SHAPE_BIT];
	assign pending_cfg.height = cursor_height_reg[CURSOR_FIELD_MSB:CURSOR_FIELD_LSB];
	assign pending_cfg.width = cursor_width_reg[CURSOR_FIELD_MSB:CURSOR_FIELD_LSB];

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			active_cfg_reg <= '0;
		end else if (frame_start_i) begin
			active_cfg_reg <= pending_cfg;
		end
	end

	// Active fields lag the drawing copy by one clock, in step with the pixel
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cursor_shape_select_o <= CURSOR_SHAPE_UNDERSCORE;
		end else begin
			cursor_shape_select_o <= active_cfg_reg.shape;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cursor_horizontal_field_o <= 4'h0;
		end else begin
			cursor_horizontal_field_o <= active_cfg_reg.width;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cursor_vertical_field_o <= 4'h0;
		end else begin
			cursor_vertical_field_o <= active_cfg_reg.height;
		end
	end

	// Cursor pixel within the character cell at the cursor address
	always_comb begin
		cursor_hit = 1'b0;
		if (at_cursor_address_i && cell_pixel_i <= active_cfg_reg.width) begin
			if (active_cfg_reg.shape == CURSOR_SHAPE_BLOCK) begin
				cursor_hit = cell_line_i <= active_cfg_reg.height;
			end else begin
				cursor_hit = cell_line_i == active_cfg_reg.height;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cursor_pixel_o <= 1'b0;
		end else begin
			cursor_pixel_o <= cursor_hit;
		end
	end

	// Derived block sizes
	block_sizer sizer (
		.block_one_line_count_i(block_one_line_count_i),
		.block_two_line_count_i(block_two_line_count_i),
		.lines_per_frame_i(lines_per_frame_i),
		.dual_panel_i(dual_panel_i),
		.sizes_o(sizes)
	);

	// Registered so the refresh timing never sees the sizer's ripple
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			block_three_line_count_o <= 8'h00;
		end else begin
			block_three_line_count_o <= sizes.block_three_line_count;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			block_four_line_count_o <= 8'h00;
		end else begin
			block_four_line_count_o <= sizes.block_four_line_count;
		end
	end

	// Blank counts stay zero outside dual panel mode
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			block_one_blank_lines_o <= 8'h00;
		end else begin
			block_one_blank_lines_o <= sizes.block_one_blank_lines;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			block_two_blank_lines_o <= 8'h00;
		end else begin
			block_two_blank_lines_o <= sizes.block_two_blank_lines;
		end
	end
endmodule // lcd_cursor_shape_and_block_sizing
`default_nettype wire

// *** lcd_cursor_shape_and_block_sizing_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module lcd_cursor_shape_and_block_sizing_checker
	import cursor_sizing_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Host pins
	input wire logic host_rd_n_i,
	input wire logic [7:0] host_data_o,
	input wire logic host_data_oe_o,
	// Geometry and refresh
	input wire logic [7:0] block_one_line_count_i,
	input wire logic [7:0] block_two_line_count_i,
	input wire logic [7:0] lines_per_frame_i,
	input wire logic dual_panel_i,
	input wire logic frame_start_i,
	input wire logic at_cursor_address_i,
	input wire logic [3:0] cell_pixel_i,
	input wire logic [3:0] cell_line_i,
	// Outputs watched
	input wire logic [7:0] block_three_line_count_o,
	input wire logic [7:0] block_four_line_count_o,
	input wire logic [7:0] block_one_blank_lines_o,
	input wire logic [7:0] block_two_blank_lines_o,
	input wire logic cursor_pixel_o,
	input wire logic cursor_shape_select_o,
	input wire logic [3:0] cursor_horizontal_field_o,
	input wire logic [3:0] cursor_vertical_field_o
);
	// Nine bits so a full 256 line frame does not wrap
	logic [8:0] half;
	logic [8:0] blank_one;
	logic [8:0] blank_two;
	logic [7:0] half_m1;
	logic [7:0] min_b;
	assign half = ({1'b0, lines_per_frame_i} + 9'h001) >> 1;
	assign half_m1 = half[7:0] - 8'h01;
	assign blank_one = (half > {1'b0, block_one_line_count_i} + 9'h001) ?
		half - {1'b0, block_one_line_count_i} - 9'h001 : 9'h000;
	assign blank_two = (half > {1'b0, block_two_line_count_i} + 9'h001) ?
		half - {1'b0, block_two_line_count_i} - 9'h001 : 9'h000;
	assign min_b = (block_one_line_count_i < block_two_line_count_i) ?
		block_one_line_count_i : block_two_line_count_i;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	chk_oe_after_strobe: assert property ($rose(host_data_oe_o) |->
		!$past(host_rd_n_i, 2) && !$past(host_rd_n_i, 3)) else $error("read data without strobe");
	chk_idle_data_zero: assert property (!host_data_oe_o |-> host_data_o == 8'h00)
		else $error("data bus not zero while idle");
	chk_block_three_min: assert property ($past(reset_n_i) && !$past(dual_panel_i) |->
		block_three_line_count_o == $past(min_b)) else $error("block three not minimum");
	chk_block_four_frame: assert property ($past(reset_n_i) && !$past(dual_panel_i) |->
		block_four_line_count_o == $past(lines_per_frame_i)) else $error("block four wrong");
	chk_single_no_blank: assert property ($past(reset_n_i) && !$past(dual_panel_i) |->
		block_one_blank_lines_o == 8'h00 && block_two_blank_lines_o == 8'h00)
		else $error("blanking in single panel");
	chk_dual_half_sizes: assert property ($past(reset_n_i) && $past(dual_panel_i) |->
		block_three_line_count_o == $past(half_m1) && block_four_line_count_o == $past(half_m1))
		else $error("dual block sizes wrong");
	chk_dual_blank_count: assert property ($past(reset_n_i) && $past(dual_panel_i) |->
		block_one_blank_lines_o == $past(blank_one[7:0])
		&& block_two_blank_lines_o == $past(blank_two[7:0])) else $error("dual blanking wrong");
	chk_cursor_pixel_on: assert property ($past(reset_n_i) &&
		$stable({cursor_shape_select_o, cursor_horizontal_field_o, cursor_vertical_field_o}) |->
		cursor_pixel_o == ($past(at_cursor_address_i)
		&& $past(cell_pixel_i) <= cursor_horizontal_field_o
		&& (cursor_shape_select_o ? $past(cell_line_i) <= cursor_vertical_field_o
		: $past(cell_line_i) == cursor_vertical_field_o))) else $error("cursor pixel wrong");
	chk_cfg_at_frame: assert property (
		$changed({cursor_shape_select_o, cursor_horizontal_field_o, cursor_vertical_field_o})
		|-> $past(frame_start_i) || $past(frame_start_i, 2)) else $error("config moved off frame");
endmodule // lcd_cursor_shape_and_block_sizing_checker
bind lcd_cursor_shape_and_block_sizing lcd_cursor_shape_and_block_sizing_checker u_chk (
	.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .host_rd_n_i(host_rd_n_i),
	.host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
	.block_one_line_count_i(block_one_line_count_i),
	.block_two_line_count_i(block_two_line_count_i),
	.lines_per_frame_i(lines_per_frame_i), .dual_panel_i(dual_panel_i),
	.frame_start_i(frame_start_i), .at_cursor_address_i(at_cursor_address_i),
	.cell_pixel_i(cell_pixel_i), .cell_line_i(cell_line_i),
	.block_three_line_count_o(block_three_line_count_o),
	.block_four_line_count_o(block_four_line_count_o),
	.block_one_blank_lines_o(block_one_blank_lines_o),
	.block_two_blank_lines_o(block_two_blank_lines_o),
	.cursor_pixel_o(cursor_pixel_o), .cursor_shape_select_o(cursor_shape_select_o),
	.cursor_horizontal_field_o(cursor_horizontal_field_o),
	.cursor_vertical_field_o(cursor_vertical_field_o));
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model
	import cursor_sizing_pkg::*;
(
	// Clock and read data
	input wire logic clk_sys_i,
	input wire logic [7:0] rd_data_i,
	// Host pins
	output host_pins_type pins_o
);
	initial pins_o = '{wr_n: 1'b1, rd_n: 1'b1, cmd: 1'b0, indirect: 1'b0, addr: 8'h00, data: 8'h00};
	// Pins settle 3 clocks before the strobe, strobe low 5, high 4
	task automatic access(input logic wr, input logic ind, input logic cmd,
		input logic [7:0] addr, input logic [7:0] data, output logic [7:0] q);
		@(posedge clk_sys_i);
		pins_o <= '{wr_n: 1'b1, rd_n: 1'b1, cmd: cmd, indirect: ind, addr: addr, data: data};
		repeat (3) @(posedge clk_sys_i);
		if (wr) pins_o.wr_n <= 1'b0;
		else pins_o.rd_n <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		q = rd_data_i;
		pins_o.wr_n <= 1'b1;
		pins_o.rd_n <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		// Released bus shows no stale byte
		pins_o.data <= ~data;
	endtask
endmodule // host_model
`default_nettype wire

// *** lcd_cursor_shape_and_block_sizing_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module lcd_cursor_shape_and_block_sizing_tb_top;
	import cursor_sizing_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	host_pins_type pins;
	logic [7:0] rdata;
	logic oe;
	logic [7:0] b1 = 8'h00, b2 = 8'h00, lpf = 8'h00;
	logic dual = 1'b0, fs = 1'b0, at = 1'b0;
	logic [3:0] px = 4'h0, ln = 4'h0;
	logic [7:0] b3, b4, k1, k2, q;
	logic pix, shp;
	logic [3:0] hf, vf;
	int n_fail = 0, tests_run = 0, cycles = 0;
	initial forever #50 clk_sys_i = ~clk_sys_i;
	host_model u_host (.clk_sys_i(clk_sys_i), .rd_data_i(rdata), .pins_o(pins));
	lcd_cursor_shape_and_block_sizing dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.host_wr_n_i(pins.wr_n), .host_rd_n_i(pins.rd_n), .host_cmd_i(pins.cmd),
		.host_indirect_i(pins.indirect), .host_addr_i(pins.addr), .host_data_i(pins.data),
		.host_data_o(rdata), .host_data_oe_o(oe), .block_one_line_count_i(b1),
		.block_two_line_count_i(b2), .lines_per_frame_i(lpf), .dual_panel_i(dual),
		.frame_start_i(fs), .at_cursor_address_i(at), .cell_pixel_i(px), .cell_line_i(ln),
		.block_three_line_count_o(b3), .block_four_line_count_o(b4),
		.block_one_blank_lines_o(k1), .block_two_blank_lines_o(k2), .cursor_pixel_o(pix),
		.cursor_shape_select_o(shp), .cursor_horizontal_field_o(hf),
		.cursor_vertical_field_o(vf));
	task automatic test_done;
		if (n_fail == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic ind, input logic cmd, input logic [7:0] a, input logic [7:0] d);
		u_host.access(1'b1, ind, cmd, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		u_host.access(1'b0, 1'b0, 1'b0, a, 8'h00, q);
		chk(q, exp);
		chk({7'h00, oe}, 8'h00);
	endtask
	task automatic frame;
		@(posedge clk_sys_i) fs <= 1'b1;
		@(posedge clk_sys_i) fs <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic pixel(input logic a, input logic [3:0] p, input logic [3:0] l, input logic e);
		@(posedge clk_sys_i);
		at <= a;
		px <= p;
		ln <= l;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk({7'h00, pix}, {7'h00, e});
	endtask
	task automatic geo(input logic [7:0] n1, n2, f, input logic d, input logic [7:0] e3, e4, e1, e2);
		@(posedge clk_sys_i);
		b1 <= n1;
		b2 <= n2;
		lpf <= f;
		dual <= d;
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(b3, e3);
		chk(b4, e4);
		chk(k1, e1);
		chk(k2, e2);
	endtask
	// Hang guard, the run needs well under a thousand cycles
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		rd(CURSOR_WIDTH_OFFSET, CURSOR_WIDTH_RESET);
		rd(CURSOR_HEIGHT_OFFSET, CURSOR_HEIGHT_RESET);
		rd(8'h10, UNMAPPED_READ_VALUE);
		// Width 8 and height 4 fit an 8x8 cell, block shape for graphics
		wr(1'b0, 1'b0, 8'h15, 8'hf7);
		wr(1'b0, 1'b0, 8'h16, 8'hf3);
		rd(8'h15, 8'h07);
		rd(8'h16, 8'h83);
		chk({3'h0, shp, hf}, 8'h00);
		frame();
		chk({3'h0, shp, hf}, 8'h17);
		chk({4'h0, vf}, 8'h03);
		pixel(1'b1, 4'h7, 4'h3, 1'b1);
		pixel(1'b1, 4'h8, 4'h0, 1'b0);
		pixel(1'b1, 4'h0, 4'h4, 1'b0);
		pixel(1'b0, 4'h0, 4'h0, 1'b0);
		wr(1'b1, 1'b1, 8'h00, CURSOR_FORM_COMMAND_CODE);
		wr(1'b1, 1'b0, 8'h00, 8'h02);
		wr(1'b1, 1'b0, 8'h00, 8'h05);
		wr(1'b1, 1'b0, 8'h00, 8'h0f);
		wr(1'b1, 1'b1, 8'h00, ~CURSOR_FORM_COMMAND_CODE);
		wr(1'b1, 1'b0, 8'h00, 8'h09);
		rd(8'h15, 8'h02);
		rd(8'h16, 8'h05);
		frame();
		pixel(1'b1, 4'h2, 4'h5, 1'b1);
		pixel(1'b1, 4'h1, 4'h4, 1'b0);
		pixel(1'b1, 4'h3, 4'h5, 1'b0);
		geo(8'h0a, 8'h06, 8'hef, 1'b0, 8'h06, 8'hef, 8'h00, 8'h00);
		geo(8'h03, 8'h09, 8'hef, 1'b0, 8'h03, 8'hef, 8'h00, 8'h00);
		geo(8'h50, 8'h77, 8'hef, 1'b1, 8'h77, 8'h77, 8'h27, 8'h00);
		geo(8'h77, 8'h00, 8'hff, 1'b1, 8'h7f, 8'h7f, 8'h08, 8'h7f);
		test_done();
	end
endmodule // lcd_cursor_shape_and_block_sizing_tb_top
`default_nettype wire
